// ---- rtl/bpx_bitram.sv ----
/*
  Bit-addressable RAM block holding the 128 software flags.
  Assumes the caller only presents direct bit addresses 0 to 127.
*/
`timescale 1ns/100ps
`include "bpx_cfg.svh"
module bpx_bitram import bpx_pkg::*; #(
  parameter int BYTES = `BPX_RAM_LAST - `BPX_RAM_BASE + 1
) (
  // Clock and control
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // Bit access
  input wire logic [6:0] rd_idx_i,
  output logic rd_bit_o,
  input wire logic wr_en_i,
  input wire logic [6:0] wr_idx_i,
  input wire logic wr_val_i
);
  logic [7:0] mem [BYTES];

  assign rd_bit_o = mem[rd_idx_i[6:3]][rd_idx_i[2:0]];

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int k = 0; k < BYTES; k++) begin
        mem[k] <= `BPX_ZERO_RST;
      end
    end else if (ce_i && wr_en_i) begin
      mem[wr_idx_i[6:3]][wr_idx_i[2:0]] <= wr_val_i;
    end
  end
endmodule

// ---- rtl/bpx_cfg.svh ----
/*
  Constants of the one-bit Boolean execution unit: special register
  addresses, flag positions, reset values and decimal-adjust constants.
  Assumes inclusion by bare name from every file that needs them.
*/
`ifndef BPX_CFG_SVH
`define BPX_CFG_SVH
`define BPX_RAM_BASE 8'h20
`define BPX_RAM_LAST 8'h2F
`define BPX_SFR_P0 8'h80
`define BPX_SFR_TIMER_CONTROL_REG 8'h88
`define BPX_SFR_P1 8'h90
`define BPX_SFR_P2 8'hA0
`define BPX_SFR_IE 8'hA8
`define BPX_SFR_P3 8'hB0
`define BPX_SFR_IP 8'hB8
`define BPX_SFR_PSW 8'hD0
`define BPX_SFR_ACC 8'hE0
`define BPX_SFR_B 8'hF0
`define BPX_PSW_CY 7
`define BPX_PSW_AC 6
`define BPX_PSW_OV 2
`define BPX_PSW_P 0
`define BPX_TIMER_CONTROL_REG_TF1 7
`define BPX_TIMER_CONTROL_REG_TR1 6
`define BPX_TIMER_CONTROL_REG_TF0 5
`define BPX_TIMER_CONTROL_REG_TR0 4
`define BPX_PORT_RST 8'hFF
`define BPX_ZERO_RST 8'h00
`define BPX_DA_LIMIT 4'h9
`define BPX_DA_LOW 9'h006
`define BPX_DA_HIGH 9'h060
`endif

// ---- rtl/bpx_exec.sv ----
/*
  Execution unit of the one-bit Boolean processor with the byte
  operations that touch the carry, and the bit-addressable registers.
  Assumes a fetch stage supplies the decoded operation, the bit
  address, displacement, operand bytes and the incremented program
  counter, and takes the branch target from target_o.
*/
`timescale 1ns/100ps
`include "bpx_cfg.svh"
module bpx_exec import bpx_pkg::*; (
  // Clock and control
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // Instruction request
  input wire logic valid_i,
  input wire bpx_op_e op_i,
  input wire logic [7:0] bit_addr_i,
  input wire logic [7:0] rel_i,
  input wire logic [7:0] data_i,
  input wire logic [7:0] lhs_i,
  input wire logic [15:0] next_pc_i,
  // Pins and timer events
  input wire logic [7:0] p0_pin_i,
  input wire logic [7:0] p1_pin_i,
  input wire logic [7:0] p2_pin_i,
  input wire logic [7:0] p3_pin_i,
  input wire logic tf0_set_i,
  input wire logic tf1_set_i,
  // Completion
  output logic ready_o,
  output logic done_o,
  output logic branch_o,
  output logic [15:0] target_o,
  // Register state
  output logic carry_o,
  output logic [7:0] acc_o,
  output logic [7:0] b_o,
  output logic [7:0] psw_o,
  output logic [7:0] timer_control_reg_o,
  output logic [7:0] ie_o,
  output logic [7:0] ip_o,
  output logic tr0_o,
  output logic tr1_o,
  output logic [7:0] p0_o,
  output logic [7:0] p1_o,
  output logic [7:0] p2_o,
  output logic [7:0] p3_o
);
  localparam logic [7:0] PORT_SFR [4] = '{`BPX_SFR_P0, `BPX_SFR_P1,
                                          `BPX_SFR_P2, `BPX_SFR_P3};

  function automatic logic two_cycle(input bpx_op_e op);
    case (op)
      OP_MOV_BIT_C, OP_AND_CARRY_OP, OP_AND_CARRY_NOT,
      OP_OR_CARRY_OP, OP_OR_CARRY_NOT, OP_JUMP_ON_CARRY,
      OP_JUMP_ON_NO_CARRY, OP_JUMP_ON_BIT_SET, OP_JUMP_ON_BIT_CLEAR,
      OP_JUMP_TEST_AND_CLEAR, OP_SHORT_RELATIVE_JUMP,
      OP_COMPARE_JUMP_UNEQUAL_ACC,
      OP_COMPARE_JUMP_UNEQUAL_REG: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // Byte that holds a special-register bit
  function automatic logic [7:0] sfr_base(input logic [7:0] a);
    return {a[7:3], 3'b000};
  endfunction

  function automatic logic hits(input logic [7:0] a,
                                input logic [7:0] base);
    return a[7] && (sfr_base(a) == base);
  endfunction

  bpx_state_e state;
  logic cnt;
  bpx_op_e cap_op;
  logic [7:0] cap_addr, cap_rel, cap_data, cap_lhs;
  logic [15:0] cap_pc;
  logic [7:0] acc, b_reg, program_status_word, timer_control_reg, ie, ip;
  logic [7:0] port_q [4];
  logic [31:0] pin_meta, pin_sync;
  logic exec_now, ram_bit, src_bit, latch_bit, bw_en, bw_val, take;
  logic [7:0] rd_byte, rmw_byte, next_acc, next_psw;
  logic [2:0] pos;
  logic [8:0] add_full, sub_full, da_t;
  logic [4:0] add_lo, sub_lo;
  logic add_cin, da_cy;
  logic [15:0] rel_ext;

  assign pos = cap_addr[2:0];
  assign exec_now = ce_i && (state == ST_BUSY) && !cnt;
  assign rel_ext = {{8{cap_rel[7]}}, cap_rel};

  // Pins change outside our clock, so two stages before any reader
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_meta <= 32'h00000000;
      pin_sync <= 32'h00000000;
    end else if (ce_i) begin
      pin_meta <= {p3_pin_i, p2_pin_i, p1_pin_i, p0_pin_i};
      pin_sync <= pin_meta;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= ST_IDLE;
      cnt <= 1'b0;
      ready_o <= 1'b1;
    end else if (ce_i) begin
      case (state)
        ST_IDLE: begin
          if (valid_i) begin
            state <= ST_BUSY;
            cnt <= two_cycle(op_i);
            ready_o <= 1'b0;
          end
        end
        ST_BUSY: begin
          if (cnt) begin
            cnt <= 1'b0;
          end else begin
            state <= ST_IDLE;
            ready_o <= 1'b1;
          end
        end
        default: begin
          state <= ST_IDLE;
          ready_o <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cap_op <= OP_NOP;
      cap_addr <= `BPX_ZERO_RST;
      cap_rel <= `BPX_ZERO_RST;
      cap_data <= `BPX_ZERO_RST;
      cap_lhs <= `BPX_ZERO_RST;
      cap_pc <= 16'h0000;
    end else if (ce_i && ready_o && valid_i) begin
      cap_op <= op_i;
      cap_addr <= bit_addr_i;
      cap_rel <= rel_i;
      cap_data <= data_i;
      cap_lhs <= lhs_i;
      cap_pc <= next_pc_i;
    end
  end

  bpx_bitram u_ram (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .rd_idx_i(cap_addr[6:0]),
    .rd_bit_o(ram_bit),
    .wr_en_i(exec_now && bw_en && !cap_addr[7]),
    .wr_idx_i(cap_addr[6:0]),
    .wr_val_i(bw_val)
  );

  // Tests read the pins; modify operations read the output latch
  always_comb begin
    rd_byte = `BPX_ZERO_RST;
    rmw_byte = `BPX_ZERO_RST;
    case (sfr_base(cap_addr))
      `BPX_SFR_P0: begin
        rd_byte = pin_sync[7:0];
        rmw_byte = port_q[0];
      end
      `BPX_SFR_P1: begin
        rd_byte = pin_sync[15:8];
        rmw_byte = port_q[1];
      end
      `BPX_SFR_P2: begin
        rd_byte = pin_sync[23:16];
        rmw_byte = port_q[2];
      end
      `BPX_SFR_P3: begin
        rd_byte = pin_sync[31:24];
        rmw_byte = port_q[3];
      end
      `BPX_SFR_TIMER_CONTROL_REG: rd_byte = timer_control_reg;
      `BPX_SFR_IE: rd_byte = ie;
      `BPX_SFR_IP: rd_byte = ip;
      `BPX_SFR_PSW: rd_byte = program_status_word;
      `BPX_SFR_ACC: rd_byte = acc;
      `BPX_SFR_B: rd_byte = b_reg;
      default: rd_byte = `BPX_ZERO_RST;
    endcase
    if (!rmw_byte_is_port(sfr_base(cap_addr))) begin
      rmw_byte = rd_byte;
    end
    src_bit = cap_addr[7] ? rd_byte[pos] : ram_bit;
    latch_bit = cap_addr[7] ? rmw_byte[pos] : ram_bit;
  end

  function automatic logic rmw_byte_is_port(input logic [7:0] a);
    return (a == `BPX_SFR_P0) || (a == `BPX_SFR_P1) ||
           (a == `BPX_SFR_P2) || (a == `BPX_SFR_P3);
  endfunction

  // Byte arithmetic and decimal adjust
  always_comb begin
    add_cin = (cap_op == OP_SUM_WITH_CARRY_IN) && program_status_word[`BPX_PSW_CY];
    add_full = {1'b0, acc} + {1'b0, cap_data} + {8'h00, add_cin};
    add_lo = {1'b0, acc[3:0]} + {1'b0, cap_data[3:0]} + {4'h0, add_cin};
    sub_full = {1'b0, acc} - {1'b0, cap_data} -
               {8'h00, program_status_word[`BPX_PSW_CY]};
    sub_lo = {1'b0, acc[3:0]} - {1'b0, cap_data[3:0]} -
             {4'h0, program_status_word[`BPX_PSW_CY]};
    da_t = {1'b0, acc};
    da_cy = program_status_word[`BPX_PSW_CY];
    if ((acc[3:0] > `BPX_DA_LIMIT) || program_status_word[`BPX_PSW_AC]) begin
      da_t = da_t + `BPX_DA_LOW;
    end
    if (da_t[8] || da_cy || (da_t[7:4] > `BPX_DA_LIMIT)) begin
      da_t = da_t + `BPX_DA_HIGH;
      da_cy = 1'b1;
    end
    da_cy = da_cy || da_t[8];
  end

  always_comb begin
    next_acc = acc;
    next_psw = program_status_word;
    bw_en = 1'b0;
    bw_val = 1'b0;
    take = 1'b0;
    case (cap_op)
      OP_SET_C: next_psw[`BPX_PSW_CY] = 1'b1;
      OP_ZERO_C: next_psw[`BPX_PSW_CY] = 1'b0;
      OP_INVERT_C: next_psw[`BPX_PSW_CY] = !program_status_word[`BPX_PSW_CY];
      OP_SET_BIT_OP: begin
        bw_en = 1'b1;
        bw_val = 1'b1;
      end
      OP_ZERO_BIT_OP: bw_en = 1'b1;
      OP_INVERT_BIT_OP: begin
        bw_en = 1'b1;
        bw_val = !latch_bit;
      end
      OP_MOV_C_BIT: next_psw[`BPX_PSW_CY] = src_bit;
      OP_MOV_BIT_C: begin
        bw_en = 1'b1;
        bw_val = program_status_word[`BPX_PSW_CY];
      end
      // Source bit is only read here, never written back
      OP_AND_CARRY_OP: next_psw[`BPX_PSW_CY] =
          program_status_word[`BPX_PSW_CY] && src_bit;
      OP_AND_CARRY_NOT: next_psw[`BPX_PSW_CY] =
          program_status_word[`BPX_PSW_CY] && !src_bit;
      OP_OR_CARRY_OP: next_psw[`BPX_PSW_CY] =
          program_status_word[`BPX_PSW_CY] || src_bit;
      OP_OR_CARRY_NOT: next_psw[`BPX_PSW_CY] =
          program_status_word[`BPX_PSW_CY] || !src_bit;
      OP_JUMP_ON_CARRY: take = program_status_word[`BPX_PSW_CY];
      OP_JUMP_ON_NO_CARRY: take = !program_status_word[`BPX_PSW_CY];
      OP_JUMP_ON_BIT_SET: take = src_bit;
      OP_JUMP_ON_BIT_CLEAR: take = !src_bit;
      OP_JUMP_TEST_AND_CLEAR: begin
        take = latch_bit;
        bw_en = latch_bit;
      end
      OP_SHORT_RELATIVE_JUMP: take = 1'b1;
      OP_ROTATE_LEFT_VIA_CARRY: begin
        next_acc = {acc[6:0], program_status_word[`BPX_PSW_CY]};
        next_psw[`BPX_PSW_CY] = acc[7];
      end
      OP_ROTATE_RIGHT_VIA_CARRY: begin
        next_acc = {program_status_word[`BPX_PSW_CY], acc[7:1]};
        next_psw[`BPX_PSW_CY] = acc[0];
      end
      OP_SUM, OP_SUM_WITH_CARRY_IN: begin
        next_acc = add_full[7:0];
        next_psw[`BPX_PSW_CY] = add_full[8];
        next_psw[`BPX_PSW_AC] = add_lo[4];
        next_psw[`BPX_PSW_OV] = (acc[7] == cap_data[7]) &&
                                (add_full[7] != acc[7]);
      end
      OP_SUBTRACT_WITH_BORROW: begin
        next_acc = sub_full[7:0];
        next_psw[`BPX_PSW_CY] = sub_full[8];
        next_psw[`BPX_PSW_AC] = sub_lo[4];
        next_psw[`BPX_PSW_OV] = (acc[7] != cap_data[7]) &&
                                (sub_full[7] != acc[7]);
      end
      OP_DECIMAL_ADJUST: begin
        next_acc = da_t[7:0];
        next_psw[`BPX_PSW_CY] = da_cy;
      end
      OP_COMPARE_JUMP_UNEQUAL_ACC: begin
        take = acc != cap_data;
        next_psw[`BPX_PSW_CY] = acc < cap_data;
      end
      OP_COMPARE_JUMP_UNEQUAL_REG: begin
        take = cap_lhs != cap_data;
        next_psw[`BPX_PSW_CY] = cap_lhs < cap_data;
      end
      OP_LOAD_PSW: next_psw = cap_data;
      OP_LOAD_ACC: next_acc = cap_data;
      default: take = 1'b0;
    endcase
    if (bw_en && hits(cap_addr, `BPX_SFR_ACC)) begin
      next_acc[pos] = bw_val;
    end
    if (bw_en && hits(cap_addr, `BPX_SFR_PSW)) begin
      next_psw[pos] = bw_val;
    end
    // Parity always follows the accumulator, writes to it are lost
    next_psw[`BPX_PSW_P] = ^next_acc;
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      acc <= `BPX_ZERO_RST;
      program_status_word <= `BPX_ZERO_RST;
    end else if (exec_now) begin
      acc <= next_acc;
      program_status_word <= next_psw;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      b_reg <= `BPX_ZERO_RST;
      ie <= `BPX_ZERO_RST;
      ip <= `BPX_ZERO_RST;
    end else if (exec_now && bw_en) begin
      if (hits(cap_addr, `BPX_SFR_B)) b_reg[pos] <= bw_val;
      if (hits(cap_addr, `BPX_SFR_IE)) ie[pos] <= bw_val;
      if (hits(cap_addr, `BPX_SFR_IP)) ip[pos] <= bw_val;
    end
  end

  // A timer event in the same cycle as a clear keeps the flag set
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      timer_control_reg <= `BPX_ZERO_RST;
    end else if (ce_i) begin
      if (exec_now && bw_en && hits(cap_addr, `BPX_SFR_TIMER_CONTROL_REG)) begin
        timer_control_reg[pos] <= bw_val;
      end
      if (tf0_set_i) timer_control_reg[`BPX_TIMER_CONTROL_REG_TF0] <= 1'b1;
      if (tf1_set_i) timer_control_reg[`BPX_TIMER_CONTROL_REG_TF1] <= 1'b1;
    end
  end

  for (genvar i = 0; i < 4; i++) begin : g_port
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        port_q[i] <= `BPX_PORT_RST;
      end else if (exec_now && bw_en && hits(cap_addr, PORT_SFR[i])) begin
        port_q[i][pos] <= bw_val;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      done_o <= 1'b0;
      branch_o <= 1'b0;
      target_o <= 16'h0000;
    end else if (ce_i) begin
      done_o <= exec_now;
      branch_o <= exec_now && take;
      if (exec_now) begin
        target_o <= cap_pc + rel_ext;
      end
    end
  end

  assign carry_o = program_status_word[`BPX_PSW_CY];
  assign acc_o = acc;
  assign b_o = b_reg;
  assign psw_o = program_status_word;
  assign timer_control_reg_o = timer_control_reg;
  assign ie_o = ie;
  assign ip_o = ip;
  assign tr0_o = timer_control_reg[`BPX_TIMER_CONTROL_REG_TR0];
  assign tr1_o = timer_control_reg[`BPX_TIMER_CONTROL_REG_TR1];
  assign p0_o = port_q[0];
  assign p1_o = port_q[1];
  assign p2_o = port_q[2];
  assign p3_o = port_q[3];

  sequence s_take(bpx_op_e x);
    ready_o && valid_i && (op_i == x);
  endsequence
  sequence s_busy(int n);
    !ready_o && !done_o;
  endsequence

  property p_move_in(bpx_op_e x);
    @(posedge core_clk_i) disable iff (!nrst_i || !ce_i)
    s_take(x) |=> !ready_o ##1 (done_o && ready_o);
  endproperty
  a_move_in: assert property (p_move_in(OP_MOV_C_BIT))
    else $error("bit-to-carry move not one cycle");

  property p_move_out;
    @(posedge core_clk_i) disable iff (!nrst_i || !ce_i)
    s_take(OP_MOV_BIT_C) |=> !ready_o [*2] ##1 done_o;
  endproperty
  a_move_out: assert property (p_move_out)
    else $error("carry-to-bit move not two cycles");

  property p_jump_carry;
    @(posedge core_clk_i) disable iff (!nrst_i)
    done_o && (cap_op == OP_JUMP_ON_CARRY) |-> branch_o == carry_o;
  endproperty
  a_jump_carry: assert property (p_jump_carry)
    else $error("jump on carry decision wrong");

  property p_jump_len;
    @(posedge core_clk_i) disable iff (!nrst_i || !ce_i)
    done_o && two_cycle(cap_op) |->
      !$past(ready_o, 1) && !$past(ready_o, 2) && $past(ready_o, 3);
  endproperty
  a_jump_len: assert property (p_jump_len)
    else $error("two-cycle instruction length wrong");

  property p_target;
    @(posedge core_clk_i) disable iff (!nrst_i)
    done_o && branch_o |-> target_o == cap_pc + rel_ext;
  endproperty
  a_target: assert property (p_target)
    else $error("branch target wrong");

  property p_tclear;
    @(posedge core_clk_i) disable iff (!nrst_i)
    done_o && branch_o && (cap_op == OP_JUMP_TEST_AND_CLEAR) &&
      !cap_addr[7] |-> !ram_bit;
  endproperty
  a_tclear: assert property (p_tclear)
    else $error("tested bit not cleared");

  property p_src_kept;
    @(posedge core_clk_i) disable iff (!nrst_i || !ce_i)
    done_o && !cap_addr[7] && (cap_op inside {OP_AND_CARRY_OP,
      OP_AND_CARRY_NOT, OP_OR_CARRY_OP, OP_OR_CARRY_NOT}) |->
      ram_bit == $past(ram_bit);
  endproperty
  a_src_kept: assert property (p_src_kept)
    else $error("logic source bit changed");

  property p_rotate;
    @(posedge core_clk_i) disable iff (!nrst_i || !ce_i)
    s_take(OP_ROTATE_LEFT_VIA_CARRY) |=> s_busy(1) ##1
      (done_o && carry_o == $past(acc_o[7]) &&
       acc_o[0] == $past(carry_o));
  endproperty
  a_rotate: assert property (p_rotate)
    else $error("rotate through carry wrong");

  property p_compare;
    @(posedge core_clk_i) disable iff (!nrst_i)
    done_o && (cap_op == OP_COMPARE_JUMP_UNEQUAL_REG) |->
      branch_o == (cap_lhs != cap_data) &&
      carry_o == (cap_lhs < cap_data);
  endproperty
  a_compare: assert property (p_compare)
    else $error("compare-jump result wrong");

  property p_overflow_set;
    @(posedge core_clk_i) disable iff (!nrst_i || !ce_i)
    tf0_set_i |=> timer_control_reg_o[`BPX_TIMER_CONTROL_REG_TF0];
  endproperty
  a_overflow_set: assert property (p_overflow_set)
    else $error("timer overflow event lost");
endmodule

// ---- rtl/bpx_pkg.sv ----
/*
  Types of the Boolean execution unit: operation codes and states.
  Assumes the decoder in front of the unit already mapped opcodes.
*/
package bpx_pkg;
  typedef enum logic [4:0] {
    OP_NOP, OP_SET_C, OP_ZERO_C, OP_INVERT_C,
    OP_SET_BIT_OP, OP_ZERO_BIT_OP, OP_INVERT_BIT_OP,
    OP_MOV_C_BIT, OP_MOV_BIT_C,
    OP_AND_CARRY_OP, OP_AND_CARRY_NOT, OP_OR_CARRY_OP, OP_OR_CARRY_NOT,
    OP_JUMP_ON_CARRY, OP_JUMP_ON_NO_CARRY,
    OP_JUMP_ON_BIT_SET, OP_JUMP_ON_BIT_CLEAR, OP_JUMP_TEST_AND_CLEAR,
    OP_SHORT_RELATIVE_JUMP,
    OP_ROTATE_LEFT_VIA_CARRY, OP_ROTATE_RIGHT_VIA_CARRY,
    OP_SUM, OP_SUM_WITH_CARRY_IN, OP_SUBTRACT_WITH_BORROW,
    OP_DECIMAL_ADJUST, OP_COMPARE_JUMP_UNEQUAL_ACC,
    OP_COMPARE_JUMP_UNEQUAL_REG, OP_LOAD_PSW, OP_LOAD_ACC
  } bpx_op_e;
  typedef enum {ST_IDLE, ST_BUSY} bpx_state_e;
endpackage

// ---- test/bpx_exec_bench.sv ----
/*
  Self-checking bench of the Boolean execution unit: bit moves, carry
  logic, relative jumps, byte ops on the carry, ports and timer flags.
  Assumes bpx_pkg is compiled first and rtl/ is on the include path.
*/
`timescale 1ns/100ps
module bpx_exec_bench import bpx_pkg::*; ;
  logic core_clk_i, nrst_i, ce_i, valid_i, tf0_set_i, tf1_set_i;
  bpx_op_e op_i;
  logic [7:0] bit_addr_i, rel_i, data_i, lhs_i;
  logic [7:0] p0_pin_i, p1_pin_i, p2_pin_i, p3_pin_i;
  logic [15:0] next_pc_i, target_o;
  logic ready_o, done_o, branch_o, carry_o, tr0_o, tr1_o;
  logic [7:0] acc_o, b_o, psw_o, timer_control_reg_o, ie_o, ip_o;
  logic [7:0] p0_o, p1_o, p2_o, p3_o;
  int errors = 0, check_count = 0, seed = 72945;
  int i, j, k;
  logic [7:0] b, a, d, r;
  logic [8:0] e;
  logic [31:0] pins;
  bpx_op_e aops [6] = '{OP_ROTATE_LEFT_VIA_CARRY,
    OP_ROTATE_RIGHT_VIA_CARRY, OP_SUM, OP_SUM_WITH_CARRY_IN,
    OP_SUBTRACT_WITH_BORROW, OP_DECIMAL_ADJUST};

  bpx_exec bpx_exec_inst (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
    .ce_i(ce_i), .valid_i(valid_i), .op_i(op_i), .bit_addr_i(bit_addr_i),
    .rel_i(rel_i), .data_i(data_i), .lhs_i(lhs_i), .next_pc_i(next_pc_i),
    .p0_pin_i(p0_pin_i), .p1_pin_i(p1_pin_i), .p2_pin_i(p2_pin_i),
    .p3_pin_i(p3_pin_i), .tf0_set_i(tf0_set_i), .tf1_set_i(tf1_set_i),
    .ready_o(ready_o), .done_o(done_o), .branch_o(branch_o),
    .target_o(target_o), .carry_o(carry_o), .acc_o(acc_o), .b_o(b_o),
    .psw_o(psw_o), .timer_control_reg_o(timer_control_reg_o), .ie_o(ie_o), .ip_o(ip_o),
    .tr0_o(tr0_o), .tr1_o(tr1_o), .p0_o(p0_o), .p1_o(p1_o), .p2_o(p2_o),
    .p3_o(p3_o));

  initial begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] seen,
                     input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Called at a falling edge with the unit idle; returns in the done cycle
  task automatic run(input bpx_op_e op, input logic [7:0] ba,
                     input logic [7:0] dv, input logic [7:0] rl,
                     input int cyc);
    int n;
    op_i = op;
    bit_addr_i = ba;
    data_i = dv;
    rel_i = rl;
    next_pc_i = 16'($random(seed));
    valid_i = 1'b1;
    @(negedge core_clk_i);
    valid_i = 1'b0;
    n = 1;
    while (done_o !== 1'b1 && n < 8) begin
      @(negedge core_clk_i);
      n++;
    end
    chk("latency", 16'(n), 16'(cyc + 1));
  endtask

  task automatic jmp(input bpx_op_e op, input logic [7:0] ba,
                     input logic [7:0] dv, input logic [7:0] rl,
                     input logic br);
    run(op, ba, dv, rl, 2);
    chk("branch", 16'(branch_o), 16'(br));
    chk("target", target_o, next_pc_i + {{8{rl[7]}}, rl});
  endtask

  function automatic logic [8:0] model(input int n, input logic [7:0] x,
                                       input logic [7:0] y, input logic c);
    logic [8:0] v;
    v = {1'b0, x};
    case (n)
      0: v = {x, c};
      1: v = {x[0], c, x[7:1]};
      2: v = v + {1'b0, y};
      3: v = v + {1'b0, y} + 9'(c);
      4: v = v - {1'b0, y} - 9'(c);
      default: begin
        if (x[3:0] > 4'h9) v = v + 9'h006;
        if (v[8:4] > 5'h09) v = v + 9'h060;
      end
    endcase
    return v;
  endfunction

  initial begin
    repeat (20000) @(posedge core_clk_i);
    errors++;
    end_of_test();
  end

  initial begin
    nrst_i = 1'b0; ce_i = 1'b1; valid_i = 1'b0; op_i = OP_NOP;
    bit_addr_i = 8'h00; rel_i = 8'h00; data_i = 8'h00; lhs_i = 8'h00;
    next_pc_i = 16'h0000; tf0_set_i = 1'b0; tf1_set_i = 1'b0;
    {p0_pin_i, p1_pin_i, p2_pin_i, p3_pin_i} = 32'h0000_0000;
    repeat (12) @(negedge core_clk_i);
    nrst_i = 1'b1;
    chk("ready", 16'(ready_o), 16'h0001);
    chk("acc", 16'(acc_o), 16'h0000);
    chk("psw", 16'(psw_o), 16'h0000);
    chk("p1", 16'(p1_o), 16'h00FF);
    chk("timer_control_reg", 16'(timer_control_reg_o), 16'h0000);
    chk("p0 p2", {p0_o, p2_o}, 16'hFFFF);
    chk("p3", 16'(p3_o), 16'h00FF);
    for (i = 0; i < 4; i++) begin
      b = (i == 0) ? 8'h7F : 8'($random(seed)) & 8'h7F;
      r = 8'($random(seed));
      run(OP_SET_BIT_OP, b, 8'h00, r, 1);
      jmp(OP_JUMP_ON_BIT_SET, b, 8'h00, r, 1'b1);
      run(OP_MOV_C_BIT, b, 8'h00, r, 1);
      chk("carry", 16'(carry_o), 16'h0001);
      run(OP_ZERO_BIT_OP, b, 8'h00, r, 1);
      jmp(OP_JUMP_ON_BIT_CLEAR, b, 8'h00, r, 1'b1);
      run(OP_MOV_C_BIT, b, 8'h00, r, 1);
      chk("carry", 16'(carry_o), 16'h0000);
      run(OP_SET_C, 8'h00, 8'h00, r, 1);
      run(OP_MOV_BIT_C, b, 8'h00, r, 2);
      jmp(OP_JUMP_TEST_AND_CLEAR, b, 8'h00, r, 1'b1);
      jmp(OP_JUMP_ON_BIT_SET, b, 8'h00, r, 1'b0);
    end
    $display("test bit moves done");
    for (j = 0; j < 16; j++) begin
      run(j[0] ? OP_SET_BIT_OP : OP_ZERO_BIT_OP, 8'h10, 8'h00, 8'h00, 1);
      run(j[1] ? OP_SET_C : OP_ZERO_C, 8'h00, 8'h00, 8'h00, 1);
      run(bpx_op_e'(OP_AND_CARRY_OP + j[3:2]), 8'h10, 8'h00, 8'h00, 2);
      case (j[3:2])
        2'd0: e[0] = j[1] & j[0];
        2'd1: e[0] = j[1] & ~j[0];
        2'd2: e[0] = j[1] | j[0];
        default: e[0] = j[1] | ~j[0];
      endcase
      chk("carry", 16'(carry_o), 16'(e[0]));
      jmp(OP_JUMP_ON_BIT_SET, 8'h10, 8'h00, 8'h05, j[0]);
    end
    for (j = 0; j < 2; j++) begin
      run(j[0] ? OP_SET_C : OP_ZERO_C, 8'h00, 8'h00, 8'h00, 1);
      jmp(OP_JUMP_ON_CARRY, 8'h00, 8'h00, 8'($random(seed)), j[0]);
      jmp(OP_JUMP_ON_NO_CARRY, 8'h00, 8'h00, 8'h80, ~j[0]);
    end
    run(OP_INVERT_C, 8'h00, 8'h00, 8'h00, 1);
    chk("carry", 16'(carry_o), 16'h0000);
    jmp(OP_SHORT_RELATIVE_JUMP, 8'h00, 8'h00, 8'h00, 1'b1);
    chk("target", target_o, next_pc_i);
    jmp(OP_SHORT_RELATIVE_JUMP, 8'h00, 8'h00, 8'h7F, 1'b1);
    jmp(OP_SHORT_RELATIVE_JUMP, 8'h00, 8'h00, 8'h80, 1'b1);
    $display("test carry logic and jumps done");
    for (k = 0; k < 18; k++) begin
      a = 8'($random(seed));
      d = 8'($random(seed));
      e[0] = (k % 6 == 5) ? 1'b0 : 1'($random(seed));
      run(OP_LOAD_PSW, 8'h00, {e[0], 7'h00}, 8'h00, 1);
      chk("carry", 16'(carry_o), 16'(e[0]));
      run(OP_LOAD_ACC, 8'h00, a, 8'h00, 1);
      run(aops[k % 6], 8'h00, d, 8'h00, 1);
      e = model(k % 6, a, d, e[0]);
      chk("acc", 16'(acc_o), 16'(e[7:0]));
      chk("carry", 16'(carry_o), 16'(e[8]));
    end
    $display("test byte ops done");
    a = 8'($random(seed));
    d = 8'($random(seed));
    run(OP_LOAD_ACC, 8'h00, a, 8'h00, 1);
    run(OP_LOAD_PSW, 8'h00, d, 8'h00, 1);
    for (k = 0; k < 8; k++) begin
      jmp(OP_JUMP_ON_BIT_SET, 8'hD0 + 8'(k), 8'h00, 8'h10,
          (k == 0) ? ^a : d[k]);
      jmp(OP_JUMP_ON_BIT_CLEAR, 8'hE0 + 8'(k), 8'h00, 8'hF0, ~a[k]);
    end
    for (k = 0; k < 6; k++) begin
      a = 8'($random(seed));
      d = (k == 0) ? a : 8'($random(seed));
      lhs_i = a;
      run(OP_LOAD_ACC, 8'h00, a, 8'h00, 1);
      jmp(k[0] ? OP_COMPARE_JUMP_UNEQUAL_REG : OP_COMPARE_JUMP_UNEQUAL_ACC,
          8'h00, d, 8'($random(seed)), a != d);
      chk("carry", 16'(carry_o), 16'(a < d));
    end
    $display("test status word and compare done");
    run(OP_INVERT_BIT_OP, 8'h92, 8'h00, 8'h00, 1);
    chk("p1", 16'(p1_o), 16'h00FB);
    run(OP_SET_BIT_OP, 8'hAF, 8'h00, 8'h00, 1);
    chk("ie", 16'(ie_o), 16'h0080);
    run(OP_SET_BIT_OP, 8'hF3, 8'h00, 8'h00, 1);
    chk("b", 16'(b_o), 16'h0008);
    run(OP_SET_BIT_OP, 8'hB9, 8'h00, 8'h00, 1);
    chk("ip", 16'(ip_o), 16'h0002);
    run(OP_SET_BIT_OP, 8'h8C, 8'h00, 8'h00, 1);
    run(OP_SET_BIT_OP, 8'h8E, 8'h00, 8'h00, 1);
    chk("run flags", 16'({tr1_o, tr0_o}), 16'h0003);
    jmp(OP_JUMP_ON_BIT_SET, 8'h8C, 8'h00, 8'h22, 1'b1);
    run(OP_ZERO_BIT_OP, 8'h8C, 8'h00, 8'h00, 1);
    chk("run flags", 16'({tr1_o, tr0_o}), 16'h0002);
    for (j = 0; j < 2; j++) begin
      {tf1_set_i, tf0_set_i} = j[0] ? 2'b10 : 2'b01;
      @(negedge core_clk_i);
      {tf1_set_i, tf0_set_i} = 2'b00;
      chk("overflow", 16'(timer_control_reg_o[5 + 2 * j]), 16'h0001);
      jmp(OP_JUMP_TEST_AND_CLEAR, 8'h8D + 8'(2 * j), 8'h00, 8'h40, 1'b1);
      chk("overflow", 16'(timer_control_reg_o[5 + 2 * j]), 16'h0000);
    end
    pins = $random(seed);
    {p3_pin_i, p2_pin_i, p1_pin_i, p0_pin_i} = pins;
    repeat (3) @(negedge core_clk_i);
    for (k = 0; k < 8; k++) begin
      i = 32'($unsigned($random(seed)) % 32);
      jmp(OP_JUMP_ON_BIT_SET, 8'h80 + 8'((i / 8) * 16 + i % 8), 8'h00,
          8'h08, pins[i]);
    end
    $display("test ports and timers done");
    end_of_test();
  end
endmodule
